// ===== dv/csb_rx_sel_model.sv
/*
 Receiving selector model that hands characters to the staging buffer.
 Assumes one-cycle requests from the bench on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module csb_rx_sel_model (
   input  wire logic       i_clk,
   input  wire logic       i_req,
   input  wire logic [7:0] i_char,
   input  wire logic       i_held,
   output logic            o_store,
   output logic [7:0]      o_char
);
   initial begin
      o_store = 1'b0;
      o_char  = 8'h00;
   end
   // Once the buffer lets go the register scrambles, so stale reads show up
   always @(posedge i_clk) begin
      o_store <= i_req;
      if (i_req) begin
         o_char <= i_char;
      end else if (!(o_store || i_held)) begin
         o_char <= ~o_char;
      end
   end
endmodule
`default_nettype wire

// ===== dv/csb_staging_buffer_asserts.sv
/*
 Concurrent checks on the staging buffer top-level ports.
 Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module csb_staging_buffer_asserts
   import csb_pkg::*;
#(
   parameter int T1_CYC = CSB_T1_CYC
) (
   input wire logic                  i_clk,
   input wire logic                  i_rstn,
   input wire logic                  i_ce,
   input wire logic                  i_rx_store,
   input wire logic                  i_rest_clear,
   input wire logic                  i_poll_rest_free,
   input wire logic                  i_tape_text,
   input wire logic                  i_tx_shift,
   input wire logic                  o_receive_stage_full_flag,
   input wire logic                  o_second_stage_full_flag,
   input wire logic                  o_third_stage_full_flag,
   input wire logic [CSB_CHAR_W-1:0] o_second_stage,
   input wire logic [CSB_CHAR_W-1:0] o_third_stage,
   input wire logic                  o_third_stage_low_bit,
   input wire logic                  o_repeat_match_flag,
   input wire logic                  o_repeat_timer_gate,
   input wire logic                  o_count_done,
   input wire logic                  o_poll_restart,
   input wire logic                  o_load_pulse,
   input wire logic                  o_character_timer
);
   int wait1;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // Unbroken run of the first transfer's enabling condition
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wait1 <= 0;
      end else begin
         wait1 <= (o_receive_stage_full_flag && !o_second_stage_full_flag) ? wait1 + 1 : 0;
      end
   end
   AST_T1_HOLD: assert property ($rose(o_second_stage_full_flag) && !$past(i_rest_clear)
      |-> $past(o_receive_stage_full_flag) && wait1 >= T1_CYC - 1) else $error("early move");
   AST_R2_CLEARED: assert property ($rose(o_third_stage_full_flag) && !$past(i_rest_clear)
      |-> !o_second_stage_full_flag && o_second_stage == 8'hFF) else $error("stage two kept");
   AST_R3_MARK: assert property (!o_third_stage_full_flag |-> o_third_stage == 8'hFF)
      else $error("empty stage three not marks");
   AST_TX_SHIFT: assert property (i_ce && i_tx_shift && o_third_stage_full_flag
      ##1 o_third_stage_full_flag |-> o_third_stage == {1'b1, $past(o_third_stage[7:1])}
      && o_third_stage_low_bit == o_third_stage[0]) else $error("bad shift");
   AST_GATE: assert property (o_repeat_timer_gate == (o_repeat_match_flag && i_tape_text))
      else $error("repeat gate wrong");
   AST_RESTART: assert property (o_poll_restart == (o_count_done && i_poll_rest_free))
      else $error("restart wrong");
   AST_DONE_FULL: assert property (o_count_done |-> o_second_stage == 8'hFF)
      else $error("done mid count");
   AST_STORE_SETS: assert property (i_ce && i_rx_store |=> o_receive_stage_full_flag)
      else $error("store lost");
   AST_CHAR_EMPTIES: assert property (o_character_timer |-> ##[0:1] !o_third_stage_full_flag)
      else $error("timer left stage three");
   AST_LOAD_PULSE: assert property ($rose(o_third_stage_full_flag) |-> ##[0:1] o_load_pulse)
      else $error("no load pulse");
endmodule
bind csb_staging_buffer csb_staging_buffer_asserts #(.T1_CYC(T1_CYC))
   csb_staging_buffer_asserts_inst (
   .i_clk, .i_rstn, .i_ce, .i_rx_store, .i_rest_clear, .i_poll_rest_free, .i_tape_text,
   .i_tx_shift, .o_receive_stage_full_flag, .o_second_stage_full_flag,
   .o_third_stage_full_flag, .o_second_stage, .o_third_stage, .o_third_stage_low_bit,
   .o_repeat_match_flag, .o_repeat_timer_gate, .o_count_done, .o_poll_restart,
   .o_load_pulse, .o_character_timer);
`default_nettype wire

// ===== dv/csb_staging_buffer_tb_top.sv
/*
 Self-checking bench for the staging buffer with shortened timer counts.
 Assumes the bound checker and the receiving selector model.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(x, y, z) begin check_count++; if ((x) !== (y)) begin fail_count++; \
   $display("MISMATCH %0t %s", $time, z); end end
module csb_staging_buffer_tb_top;
   import csb_pkg::*;
   localparam int EM = 6;
   localparam int T2C = 5;
   localparam int CHC = 20;
   int         fail_count = 0;
   int         check_count = 0;
   int         cyc = 0;
   int         nd = 0;
   int         t0;
   int         k;
   integer     seed = 32'hA0FAEEAF;
   logic       clk = 0, rstn = 0, ce = 1, req = 0, st, rc = 0, prf = 0, tape = 0;
   logic       icp = 0, fl = 0, sh = 0, idle = 0, f1, f2, f3, lb, mf, tg, dn, pr, lp, ct;
   logic [7:0] ch = 0, rxc, s2, s3, p, c, e;
   csb_staging_buffer #(.T1_CYC(4), .T2_CYC(T2C), .CHAR_CYC(CHC), .IDLE_CYC(10), .EMPTY_CYC(EM))
   csb_staging_buffer_inst (
      .i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_rx_char(rxc), .i_rx_store(st),
      .i_line_idle(idle), .i_rest_clear(rc), .i_poll_rest_free(prf), .i_tape_text(tape),
      .i_intercept(icp), .i_free_line(fl), .i_tx_shift(sh),
      .o_receive_stage_full_flag(f1), .o_second_stage_full_flag(f2),
      .o_third_stage_full_flag(f3), .o_second_stage(s2), .o_third_stage(s3),
      .o_third_stage_low_bit(lb), .o_repeat_match_flag(mf), .o_repeat_timer_gate(tg),
      .o_count_done(dn), .o_poll_restart(pr), .o_load_pulse(lp), .o_character_timer(ct));
   csb_rx_sel_model csb_rx_sel_model_inst (.i_clk(clk), .i_req(req), .i_char(ch),
      .i_held(f1), .o_store(st), .o_char(rxc));
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (pr === 1'b1) nd++;
      if (cyc == 5000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   function automatic logic hit(input int w);
      case (w)
         0: return f2 === 1'b1;
         1: return lp === 1'b1;
         2: return f3 === 1'b0;
         default: return s2 !== e;
      endcase
   endfunction
   task automatic wt(input int w);
      int n;
      n = 0;
      while (!hit(w) && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK(hit(w), 1'b1, "wait ran out")
   endtask
   task automatic put(input logic [7:0] v);
      @(posedge clk);
      req <= 1'b1;
      ch <= v;
      @(posedge clk);
      req <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   function automatic logic [7:0] ring(input logic [7:0] v);
      return {~v[0], v[7:1]};
   endfunction
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      #1;
      `CHK({f1, f2, f3, mf, s2, s3}, {4'h0, 16'hFFFF}, "reset state")
      icp <= 1'b1;
      p = 8'($random(seed));
      put(p);
      for (int i = 0; i < 8; i++) begin
         wt(0);
         `CHK({s2, f1}, {p, 1'b0}, "stage two load")
         c = ($random(seed) & 1) ? p ^ 8'hC0 : 8'($random(seed));
         tape <= 1'($random(seed));
         put(c);
         `CHK(f1, 1'b1, "stage one flag")
         wt(1);
         `CHK({s3, s2, f2}, {p, 8'hFF, 1'b0}, "stage three load")
         `CHK(mf, c[5:0] == p[5:0], "match flag")
         p = c;
      end
      wt(1);
      wt(2);
      icp <= 1'b0;
      put(8'($random(seed)));
      wt(1);
      p = 8'($random(seed));
      put(p);
      wt(0);
      // A space bit keeps the held character distinct from the rest value
      c = 8'($random(seed)) & 8'hFE;
      put(c);
      `CHK(f3, 1'b0, "unload on new char")
      wt(1);
      `CHK(s3, p, "reload after unload")
      k = 1 + {$random(seed)} % 8;
      @(posedge clk);
      sh <= 1'b1;
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      #1;
      `CHK({s3, f3}, {p, 1'b1}, "enable low freezes")
      repeat (k) @(posedge clk);
      sh <= 1'b0;
      #1;
      `CHK(s3, (p >> k) | ~(8'hFF >> k), "tx shift")
      wt(0);
      `CHK(s2, c, "held char")
      e = s2;
      t0 = cyc;
      idle <= 1'b1;
      prf <= 1'b1;
      wt(3);
      `CHK({s2, f2, cyc - t0 <= EM + 5}, {8'hFF, 2'b01}, "idle empties")
      e = 8'hFF;
      for (int j = 1; j <= 19; j++) begin
         wt(3);
         `CHK(s2, ring(e), "ring step")
         e = ring(e);
         if (j == 15) `CHK(nd, 0, "early done")
         if (j == 17) `CHK(nd, 1, "done count")
      end
      @(posedge clk);
      rc <= 1'b1;
      idle <= 1'b0;
      @(posedge clk);
      rc <= 1'b0;
      #1;
      `CHK(f2, 1'b1, "rest clear fills")
      t0 = cyc;
      fl <= 1'b1;
      wt(1);
      `CHK(s3, e, "count passed on")
      `CHK(cyc - t0, CHC + T2C + 2, "character timer delay")
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ===== hdl/csb_delay_timer.sv
/*
 Gated delay timer: a pulse each time its enable has held for another COUNT cycles.
 Assumes the enable comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module csb_delay_timer
   import csb_pkg::*;
#(
   parameter int COUNT = 16
) (
   input  wire logic i_clk,
   input  wire logic i_rstn,
   input  wire logic i_ce,
   csb_tmr_if.tmr    tif
);
   typedef struct packed {
      logic [CSB_TMR_W-1:0] cnt;
      logic                 fire;
   } csb_dt_state_type;

   csb_dt_state_type st;
   csb_dt_state_type next_st;

   always_comb begin
      next_st = st;
      next_st.fire = 1'b0;
      if (!tif.run) begin
         next_st.cnt = '0;
      end else if (st.cnt == CSB_TMR_W'(COUNT - 1)) begin
         next_st.cnt = '0;
         next_st.fire = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= '0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign tif.fire = st.fire;
endmodule
`default_nettype wire

// ===== hdl/csb_pkg.sv
/*
 Package for the character staging buffer: widths, rest values and timing counts.
 Assumes a 25 MHz system clock.
*/
package csb_pkg;
   localparam int          CSB_CLK_HZ        = 25000000;
   localparam int          CSB_CHAR_W        = 8;
   localparam logic [7:0]  CSB_REST_CHAR     = 8'hFF;
   localparam logic        CSB_FLAG_EMPTY    = 1'h0;
   localparam logic        CSB_MATCH_RST     = 1'h0;
   localparam int          CSB_CMP_BITS      = 6;
   // Times in their own units, counts derived from the clock rate
   localparam int          CSB_T1_US         = 2000;
   localparam int          CSB_T2_US         = 2500;
   localparam int          CSB_CHAR_MS       = 110;
   localparam int          CSB_IDLE_S        = 30;
   localparam int          CSB_EMPTY_MS      = 200;
   localparam int          CSB_T1_CYC        = CSB_T1_US * (CSB_CLK_HZ / 1000000);
   localparam int          CSB_T2_CYC        = CSB_T2_US * (CSB_CLK_HZ / 1000000);
   localparam int          CSB_CHAR_CYC      = CSB_CHAR_MS * (CSB_CLK_HZ / 1000);
   localparam int          CSB_IDLE_CYC      = CSB_IDLE_S * CSB_CLK_HZ;
   localparam int          CSB_EMPTY_CYC     = CSB_EMPTY_MS * (CSB_CLK_HZ / 1000);
   localparam int          CSB_TMR_W         = 32;
endpackage

// ===== hdl/csb_staging_buffer.sv
/*
 Character staging buffer: second stage (also idle ring counter and match flag)
 and third stage (also transmit shift register) behind the receive register.
 Assumes receive-side pulses are same-clock logic; the idle line is a pin.
*/
`timescale 1ns/1ps
`default_nettype none
//Contract
// - Stage one full and stage two empty: timed pulse moves character onward.
// - That enabling condition must hold about 2 ms before the pulse.
// - Stage one flag fills on each new character, empties on transfer.
// - Stage two rests all ones; transfer clears bits where stage one holds space.
// - Second transfer resets stage two to ones and marks it empty.
// - Counter shifts once every 30 seconds while the line is idle.
// - Stage two emptied within 200 ms after the line goes idle.
// - Counter is twisted ring: first bit takes inverse of last.
// - Done output after 16th shift, restarts polling in rest-free state.
// - Rest-clear marks stage two full so partial count passes onward.
// - Six bit pairs compared; match flag updated on each second transfer.
// - Match flag gates the repeat timer only during tape text.
// - Stage three empty, stage two full: after 2.5 ms copy character onward.
// - Each character timer pulse marks stage three empty.
// - New character with stages two and three full empties stage three.
// - Stage three empty forces all its bits to mark.
// - Shift moves stage three toward low bit, inserting mark at top.
// - Character timer pulses 110 ms after load when intercepting or free line.
module csb_staging_buffer
   import csb_pkg::*;
#(
   parameter int T1_CYC    = CSB_T1_CYC,
   parameter int T2_CYC    = CSB_T2_CYC,
   parameter int CHAR_CYC  = CSB_CHAR_CYC,
   parameter int IDLE_CYC  = CSB_IDLE_CYC,
   parameter int EMPTY_CYC = CSB_EMPTY_CYC
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_rstn,
   input  wire logic                  i_ce,
   input  wire logic [CSB_CHAR_W-1:0] i_rx_char,
   input  wire logic                  i_rx_store,
   input  wire logic                  i_line_idle,
   input  wire logic                  i_rest_clear,
   input  wire logic                  i_poll_rest_free,
   input  wire logic                  i_tape_text,
   input  wire logic                  i_intercept,
   input  wire logic                  i_free_line,
   input  wire logic                  i_tx_shift,
   output logic                       o_receive_stage_full_flag,
   output logic                       o_second_stage_full_flag,
   output logic                       o_third_stage_full_flag,
   output logic [CSB_CHAR_W-1:0]      o_second_stage,
   output logic [CSB_CHAR_W-1:0]      o_third_stage,
   output logic                       o_third_stage_low_bit,
   output logic                       o_repeat_match_flag,
   output logic                       o_repeat_timer_gate,
   output logic                       o_count_done,
   output logic                       o_poll_restart,
   output logic                       o_load_pulse,
   output logic                       o_character_timer
);
   typedef struct packed {
      logic                  idle_s1;
      logic                  idle_s2;
      logic                  r1_full;
      logic                  r2_full;
      logic                  r3_full;
      logic [CSB_CHAR_W-1:0] r2;
      logic [CSB_CHAR_W-1:0] r3;
      logic                  match;
      logic [CSB_TMR_W-1:0]  empty_cnt;
      logic                  emptied;
      logic                  done;
      logic                  load;
   } csb_state_type;

   csb_state_type st;
   csb_state_type next_st;

   csb_tmr_if t1_if ();
   csb_tmr_if t2_if ();
   csb_tmr_if ch_if ();
   csb_tmr_if id_if ();

   logic                  xfer1;
   logic                  xfer2;
   logic                  char_pulse;
   logic                  idle_shift;
   logic                  ring_step;
   logic [CSB_CMP_BITS-1:0] pair_eq;

   // A transfer pulse timed on a condition that dropped since is not applied
   assign xfer1      = t1_if.fire && t1_if.run;
   assign xfer2      = t2_if.fire && t2_if.run;
   assign char_pulse = ch_if.fire;
   assign idle_shift = id_if.fire;

   assign t1_if.run = st.r1_full && !st.r2_full;
   assign t2_if.run = st.r2_full && !st.r3_full;
   assign ch_if.run = st.r3_full && (i_intercept || i_free_line);
   assign id_if.run = st.idle_s2 && st.emptied;
   // Ring steps only while stage two is empty and no character lands in it
   assign ring_step  = idle_shift && !st.r2_full && !xfer1;

   genvar g;
   generate
      for (g = 0; g < CSB_CMP_BITS; g++) begin : g_cmp
         assign pair_eq[g] = (i_rx_char[g] == st.r2[g]);
      end
   endgenerate

   csb_delay_timer #(.COUNT(T1_CYC)) u_first_transfer_timer (
      .i_clk  (i_clk),
      .i_rstn (i_rstn),
      .i_ce   (i_ce),
      .tif    (t1_if)
   );
   csb_delay_timer #(.COUNT(T2_CYC)) u_second_transfer_timer (
      .i_clk  (i_clk),
      .i_rstn (i_rstn),
      .i_ce   (i_ce),
      .tif    (t2_if)
   );
   csb_delay_timer #(.COUNT(CHAR_CYC)) u_character_timer (
      .i_clk  (i_clk),
      .i_rstn (i_rstn),
      .i_ce   (i_ce),
      .tif    (ch_if)
   );
   csb_delay_timer #(.COUNT(IDLE_CYC)) u_idle_interval_timer (
      .i_clk  (i_clk),
      .i_rstn (i_rstn),
      .i_ce   (i_ce),
      .tif    (id_if)
   );

   always_comb begin
      next_st = st;
      next_st.idle_s1 = i_line_idle;
      next_st.idle_s2 = st.idle_s1;
      next_st.load = xfer2;

      // Receive register flag: a fresh store outranks the transfer clear
      if (xfer1) begin
         next_st.r1_full = 1'b0;
      end
      if (i_rx_store) begin
         next_st.r1_full = 1'b1;
      end

      // Second stage
      if (xfer2) begin
         next_st.r2 = CSB_REST_CHAR;
         next_st.r2_full = 1'b0;
         next_st.match = &pair_eq;
      end
      if (xfer1) begin
         next_st.r2 = (xfer2 ? CSB_REST_CHAR : st.r2) & i_rx_char;
         next_st.r2_full = 1'b1;
      end
      if (i_rest_clear) begin
         next_st.r2_full = 1'b1;
      end

      // Idle line: after the empty delay the partial content is dropped once
      if (!st.idle_s2) begin
         next_st.empty_cnt = '0;
         next_st.emptied = 1'b0;
      end else if (!st.emptied) begin
         if (st.empty_cnt == CSB_TMR_W'(EMPTY_CYC - 1)) begin
            next_st.emptied = 1'b1;
            // A character or rest clear in the same cycle outranks the drop
            if (!xfer1 && !i_rest_clear) begin
               next_st.r2 = CSB_REST_CHAR;
               next_st.r2_full = 1'b0;
            end
         end else begin
            next_st.empty_cnt = st.empty_cnt + 1'b1;
         end
      end
      if (ring_step) begin
         next_st.r2 = {~st.r2[0], st.r2[CSB_CHAR_W-1:1]};
      end

      // Done marks the ring coming back to all ones after a count
      next_st.done = 1'b0;
      if (ring_step && !st.r2[0]
          && (st.r2[CSB_CHAR_W-1:1] == CSB_REST_CHAR[CSB_CHAR_W-1:1])) begin
         next_st.done = 1'b1;
      end

      // Third stage flag: load outranks the unload strobes
      if (char_pulse) begin
         next_st.r3_full = 1'b0;
      end
      if (i_rx_store && st.r2_full && st.r3_full) begin
         next_st.r3_full = 1'b0;
      end
      if (i_tx_shift) begin
         next_st.r3 = {1'b1, st.r3[CSB_CHAR_W-1:1]};
      end
      if (xfer2) begin
         next_st.r3_full = 1'b1;
         next_st.r3 = st.r2;
      end
      if (!next_st.r3_full) begin
         next_st.r3 = CSB_REST_CHAR;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= '{idle_s1:   1'b0,
                 idle_s2:   1'b0,
                 r1_full:   CSB_FLAG_EMPTY,
                 r2_full:   CSB_FLAG_EMPTY,
                 r3_full:   CSB_FLAG_EMPTY,
                 r2:        CSB_REST_CHAR,
                 r3:        CSB_REST_CHAR,
                 match:     CSB_MATCH_RST,
                 empty_cnt: '0,
                 emptied:   1'b0,
                 done:      1'b0,
                 load:      1'b0};
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_receive_stage_full_flag = st.r1_full;
   assign o_second_stage_full_flag  = st.r2_full;
   assign o_third_stage_full_flag   = st.r3_full;
   assign o_second_stage            = st.r2;
   assign o_third_stage             = st.r3;
   assign o_third_stage_low_bit     = st.r3[0];
   assign o_repeat_match_flag       = st.match;
   assign o_repeat_timer_gate       = st.match && i_tape_text;
   assign o_count_done              = st.done;
   assign o_poll_restart            = st.done && i_poll_rest_free;
   assign o_load_pulse              = st.load;
   assign o_character_timer         = char_pulse;
endmodule
`default_nettype wire

// ===== hdl/csb_tmr_if.sv
/*
 Interface joining the staging buffer to its delay timers.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface csb_tmr_if;
   logic run;
   logic fire;
   modport ctl (output run, input fire);
   modport tmr (input run, output fire);
endinterface
`default_nettype wire
